// file: inc/dual_timer_pkg.sv
// Shared constants for the dual 8-bit timer/counter block
package dual_timer_pkg;

   // Peripheral transfer addresses
   localparam logic [6:0] ADDR_T0_LIMIT   = 7'h02;
   localparam logic [6:0] ADDR_T1_LIMIT   = 7'h03;
   localparam logic [6:0] ADDR_JOINT_CNT  = 7'h45;

   // Register file addresses
   localparam logic [6:0] RF_PIN_SEL      = 7'h0B;
   localparam logic [6:0] RF_T0_MODE      = 7'h11;
   localparam logic [6:0] RF_T1_MODE      = 7'h12;
   localparam logic [6:0] RF_IRQ_ALLOW    = 7'h13;
   localparam logic [6:0] RF_IRQ_PEND     = 7'h14;

   // Field positions in a mode nibble and in the pin-select nibble
   localparam int BIT_SEL_LO  = 0;
   localparam int BIT_SEL_HI  = 1;
   localparam int BIT_CLEAR   = 2;
   localparam int BIT_RUN     = 3;
   localparam int BIT_PIN_SEL = 3;

   // Reset values
   localparam logic [7:0] LIMIT_RESET     = 8'hFF;
   localparam logic [7:0] COUNT_RESET     = 8'h00;
   localparam logic [1:0] T0_SEL_RESET    = 2'h0;
   localparam logic [1:0] T1_SEL_RESET    = 2'h0;
   localparam logic       T0_RUN_RESET    = 1'h0;
   localparam logic       T1_RUN_RESET    = 1'h1;
   localparam logic       TOGGLE_RESET    = 1'h1;

   // Prescaler taps: pulse when the low bits are all ones
   localparam int         PRESC_W         = 10;
   localparam logic [9:0] MASK_DIV16      = 10'h00F;
   localparam logic [9:0] MASK_DIV64      = 10'h03F;
   localparam logic [9:0] MASK_DIV256     = 10'h0FF;
   localparam logic [9:0] MASK_DIV512     = 10'h1FF;
   localparam logic [9:0] MASK_DIV1024    = 10'h3FF;

   typedef logic [1:0] pulse_sel_t;

   typedef enum logic [1:0] {
      ST_WAIT = 2'b01,
      ST_RUN  = 2'b10
   } stab_state_t;

endpackage

// file: verilog/count_channel8.sv
// One 8-bit count register with period limit, comparator and read freeze
`timescale 1ns/1ps
module count_channel8 #(
   parameter int         CNT_W       = 8,
   parameter logic [7:0] LIMIT_INIT  = 8'hFF
) (
   input  wire logic             clock,
   input  wire logic             srst,
   input  wire logic             pulse,
   input  wire logic             hold,
   input  wire logic             countClear,
   input  wire logic             limitWe,
   input  wire logic [CNT_W-1:0] limitData,
   output logic      [CNT_W-1:0] count_ff,
   output logic                  match_ff
);
   import dual_timer_pkg::*;

   if (CNT_W != 8) begin : g_bad_width
      $error("count_channel8 supports only an 8-bit count");
   end

   logic [CNT_W-1:0] limit_ff;
   logic             pending_ff;
   logic             apply;

   // A pulse seen during a frozen read is replayed once afterwards
   assign apply = !hold && (pulse || pending_ff);

   always_ff @(posedge clock) begin
      if (srst || countClear) begin
         pending_ff <= 1'b0;
      end else if (hold) begin
         pending_ff <= pending_ff || pulse;
      end else begin
         pending_ff <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         limit_ff <= LIMIT_INIT;
      end else if (limitWe) begin
         limit_ff <= limitData;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         count_ff <= COUNT_RESET;
         match_ff <= 1'b0;
      end else if (countClear) begin
         count_ff <= COUNT_RESET;
         match_ff <= 1'b0;
      end else if (apply && count_ff == limit_ff) begin
         count_ff <= COUNT_RESET;
         match_ff <= 1'b1;
      end else begin
         count_ff <= apply ? count_ff + 1'b1 : count_ff;
         match_ff <= 1'b0;
      end
   end

   property p_incr;
      @(posedge clock) disable iff (srst)
      (apply && !countClear && count_ff != limit_ff) |=> count_ff == $past(count_ff) + 1'b1;
   endproperty
   a_incr: assert property (p_incr) else $error("count did not advance");

   property p_wrap;
      @(posedge clock) disable iff (srst)
      (apply && !countClear && count_ff == limit_ff) |=> (count_ff == 8'h00 && match_ff);
   endproperty
   a_wrap: assert property (p_wrap) else $error("match did not clear count");

   property p_clear;
      @(posedge clock) disable iff (srst)
      countClear |=> (count_ff == 8'h00 && !match_ff);
   endproperty
   a_clear: assert property (p_clear) else $error("count clear ignored");

   property p_freeze;
      @(posedge clock) disable iff (srst)
      (hold && !countClear) |=> count_ff == $past(count_ff);
   endproperty
   a_freeze: assert property (p_freeze) else $error("count moved during read");

   property p_replay;
      @(posedge clock) disable iff (srst)
      (hold && pulse && !countClear) ##1 (!hold && !countClear && count_ff != limit_ff)
         |=> count_ff == $past(count_ff) + 1'b1;
   endproperty
   a_replay: assert property (p_replay) else $error("held pulse was lost");

endmodule // count_channel8

// file: verilog/dual_eight_bit_timer_counter.sv
// Two 8-bit timer/counters with prescaler, read freeze and start-up wait
`timescale 1ns/1ps
module dual_eight_bit_timer_counter #(
   parameter logic [7:0] T1_LIMIT_INIT = dual_timer_pkg::LIMIT_RESET
) (
   input  wire logic        clock,
   input  wire logic        srst,
   input  wire logic [6:0]  periphAddr,
   input  wire logic        periphWrite,
   input  wire logic        periphRead,
   input  wire logic [15:0] transferBuffer,
   output logic      [15:0] periphRdata_ff,
   input  wire logic [6:0]  rfAddr,
   input  wire logic        rfWrite,
   input  wire logic [3:0]  rfWdata,
   output logic      [3:0]  rfRdata_ff,
   input  wire logic        extPulsePin,
   input  wire logic        globalIrqEnable,
   output logic             timer0IrqTaken_ff,
   output logic             timer1IrqTaken_ff,
   output logic             programStart_ff,
   output logic             timer0ToggleOutput_ff,
   output logic             timer0PinOut_ff,
   output logic             timer0PinOe_ff
);
   import dual_timer_pkg::*;

   if (T1_LIMIT_INIT == 8'h00) begin : g_bad_limit
      $error("timer 1 reset limit must not be zero");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   logic [PRESC_W-1:0] presc_ff;
   logic               tap16;
   logic               tap64;
   logic               tap256;
   logic               tap512;
   logic               tap1024;
   logic               extSync1_ff;
   logic               extSync2_ff;
   logic               extPrev_ff;
   logic               extEdge_ff;
   logic               timer0_run_ff;
   logic               timer1_run_ff;
   pulse_sel_t         timer0Sel_ff;
   pulse_sel_t         timer1Sel_ff;
   logic               timer0_count_clear_ff;
   logic               timer1_count_clear_ff;
   logic               timer0_pin_select_ff;
   logic               timer0_irq_allow_ff;
   logic               timer1_irq_allow_ff;
   logic               timer0_irq_pending_ff;
   logic               timer1_irq_pending_ff;
   logic               t0Src;
   logic               t1Src;
   logic               t0Pulse;
   logic               t1Pulse;
   logic [7:0]         t0Count;
   logic [7:0]         t1Count;
   logic               t0Match;
   logic               t1Match;
   logic               t0LimitWe;
   logic               t1LimitWe;
   logic               t0ModeWe;
   logic               t1ModeWe;
   logic               take0;
   logic               take1;
   logic [3:0]         nxt_rfRdata;
   stab_state_t        stab_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Prescaler, never cleared by a count clear

   always_ff @(posedge clock) begin
      if (srst) begin
         presc_ff <= '0;
      end else begin
         presc_ff <= presc_ff + 1'b1;
      end
   end

   assign tap16   = (presc_ff & MASK_DIV16) == MASK_DIV16;
   assign tap64   = (presc_ff & MASK_DIV64) == MASK_DIV64;
   assign tap256  = (presc_ff & MASK_DIV256) == MASK_DIV256;
   assign tap512  = (presc_ff & MASK_DIV512) == MASK_DIV512;
   assign tap1024 = (presc_ff & MASK_DIV1024) == MASK_DIV1024;

   ////////////////////////////////////////////////////////////////////////////
   // External pulse pin: two-flop sync, then rising edge

   always_ff @(posedge clock) begin
      if (srst) begin
         extSync1_ff <= 1'b0;
         extSync2_ff <= 1'b0;
         extPrev_ff  <= 1'b0;
         extEdge_ff  <= 1'b0;
      end else begin
         extSync1_ff <= extPulsePin;
         extSync2_ff <= extSync1_ff;
         extPrev_ff  <= extSync2_ff;
         extEdge_ff  <= extSync2_ff && !extPrev_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Count pulse selection

   always_comb begin
      case (timer0Sel_ff)
         2'h0:    t0Src = tap256;
         2'h1:    t0Src = tap64;
         2'h2:    t0Src = tap16;
         default: t0Src = extEdge_ff;
      endcase
   end

   always_comb begin
      case (timer1Sel_ff)
         2'h0:    t1Src = tap512;
         2'h1:    t1Src = tap1024;
         2'h2:    t1Src = tap256;
         default: t1Src = t0Match;
      endcase
   end

   // Stopped timers see no pulses
   assign t0Pulse = t0Src && timer0_run_ff;
   assign t1Pulse = t1Src && timer1_run_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Peripheral transfers

   assign t0LimitWe = periphWrite && periphAddr == ADDR_T0_LIMIT;
   assign t1LimitWe = periphWrite && periphAddr == ADDR_T1_LIMIT;

   // Limits are not readable; only the joint count answers a read
   always_ff @(posedge clock) begin
      if (srst) begin
         periphRdata_ff <= 16'h0000;
      end else if (periphRead && periphAddr == ADDR_JOINT_CNT) begin
         periphRdata_ff <= {t1Count, t0Count};
      end else if (periphRead) begin
         periphRdata_ff <= 16'h0000;
      end
   end

   count_channel8 #(
      .CNT_W      (8),
      .LIMIT_INIT (LIMIT_RESET)
   ) u_timer0 (
      .clock      (clock),
      .srst       (srst),
      .pulse      (t0Pulse),
      .hold       (periphRead),
      .countClear (timer0_count_clear_ff),
      .limitWe    (t0LimitWe),
      .limitData  (transferBuffer[7:0]),
      .count_ff   (t0Count),
      .match_ff   (t0Match)
   );

   count_channel8 #(
      .CNT_W      (8),
      .LIMIT_INIT (T1_LIMIT_INIT)
   ) u_timer1 (
      .clock      (clock),
      .srst       (srst),
      .pulse      (t1Pulse),
      .hold       (periphRead),
      .countClear (timer1_count_clear_ff),
      .limitWe    (t1LimitWe),
      .limitData  (transferBuffer[7:0]),
      .count_ff   (t1Count),
      .match_ff   (t1Match)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Register file writes

   assign t0ModeWe = rfWrite && rfAddr == RF_T0_MODE;
   assign t1ModeWe = rfWrite && rfAddr == RF_T1_MODE;

   always_ff @(posedge clock) begin
      if (srst) begin
         timer0_run_ff <= T0_RUN_RESET;
         timer0Sel_ff  <= T0_SEL_RESET;
      end else if (t0ModeWe) begin
         timer0_run_ff <= rfWdata[BIT_RUN];
         timer0Sel_ff  <= {rfWdata[BIT_SEL_HI], rfWdata[BIT_SEL_LO]};
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         timer1_run_ff <= T1_RUN_RESET;
         timer1Sel_ff  <= T1_SEL_RESET;
      end else if (t1ModeWe) begin
         timer1_run_ff <= rfWdata[BIT_RUN];
         timer1Sel_ff  <= {rfWdata[BIT_SEL_HI], rfWdata[BIT_SEL_LO]};
      end
   end

   // One-cycle clear pulses; nothing stores them
   always_ff @(posedge clock) begin
      if (srst) begin
         timer0_count_clear_ff <= 1'b0;
         timer1_count_clear_ff <= 1'b0;
      end else begin
         timer0_count_clear_ff <= t0ModeWe && rfWdata[BIT_CLEAR];
         timer1_count_clear_ff <= t1ModeWe && rfWdata[BIT_CLEAR];
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         timer0_pin_select_ff <= 1'b0;
         timer0_irq_allow_ff  <= 1'b0;
         timer1_irq_allow_ff  <= 1'b0;
      end else if (rfWrite && rfAddr == RF_PIN_SEL) begin
         timer0_pin_select_ff <= rfWdata[BIT_PIN_SEL];
      end else if (rfWrite && rfAddr == RF_IRQ_ALLOW) begin
         timer0_irq_allow_ff  <= rfWdata[0];
         timer1_irq_allow_ff  <= rfWdata[1];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register file reads, one cycle late

   always_comb begin
      nxt_rfRdata = 4'h0;
      if (rfAddr == RF_T0_MODE) begin
         nxt_rfRdata = {timer0_run_ff, 1'b0, timer0Sel_ff};
      end else if (rfAddr == RF_T1_MODE) begin
         nxt_rfRdata = {timer1_run_ff, 1'b0, timer1Sel_ff};
      end else if (rfAddr == RF_PIN_SEL) begin
         nxt_rfRdata = {timer0_pin_select_ff, 3'h0};
      end else if (rfAddr == RF_IRQ_ALLOW) begin
         nxt_rfRdata = {2'h0, timer1_irq_allow_ff, timer0_irq_allow_ff};
      end else if (rfAddr == RF_IRQ_PEND) begin
         nxt_rfRdata = {2'h0, timer1_irq_pending_ff, timer0_irq_pending_ff};
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         rfRdata_ff <= 4'h0;
      end else begin
         rfRdata_ff <= nxt_rfRdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt requests; a new match wins over acceptance

   // Timer 0 is served first when both are ready
   assign take0 = globalIrqEnable && timer0_irq_allow_ff && timer0_irq_pending_ff;
   assign take1 = globalIrqEnable && timer1_irq_allow_ff && timer1_irq_pending_ff
                  && !take0;

   always_ff @(posedge clock) begin
      if (srst) begin
         timer0_irq_pending_ff <= 1'b0;
         timer1_irq_pending_ff <= 1'b0;
      end else begin
         timer0_irq_pending_ff <= t0Match || (timer0_irq_pending_ff && !take0);
         timer1_irq_pending_ff <= t1Match || (timer1_irq_pending_ff && !take1);
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         timer0IrqTaken_ff <= 1'b0;
         timer1IrqTaken_ff <= 1'b0;
      end else begin
         timer0IrqTaken_ff <= take0;
         timer1IrqTaken_ff <= take1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Timer 0 toggle output and open-drain pin

   always_ff @(posedge clock) begin
      if (srst || timer0_count_clear_ff) begin
         timer0ToggleOutput_ff <= TOGGLE_RESET;
      end else if (t0Match) begin
         timer0ToggleOutput_ff <= !timer0ToggleOutput_ff;
      end
   end

   // Open drain: only ever pulls low
   always_ff @(posedge clock) begin
      if (srst) begin
         timer0PinOut_ff <= 1'b0;
         timer0PinOe_ff  <= 1'b0;
      end else begin
         timer0PinOut_ff <= 1'b0;
         timer0PinOe_ff  <= timer0_pin_select_ff && !timer0ToggleOutput_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Start-up wait: first timer 1 match releases the core

   always_ff @(posedge clock) begin
      if (srst) begin
         stab_ff <= ST_WAIT;
      end else begin
         case (stab_ff)
            ST_WAIT: stab_ff <= t1Match ? ST_RUN : ST_WAIT;
            ST_RUN:  stab_ff <= ST_RUN;
            default: stab_ff <= ST_WAIT;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         programStart_ff <= 1'b0;
      end else begin
         programStart_ff <= stab_ff == ST_RUN;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   property p_irq_set;
      @(posedge clock) disable iff (srst)
      t0Match |=> timer0_irq_pending_ff;
   endproperty
   a_irq_set: assert property (p_irq_set) else $error("match lost its request");

   property p_irq_take;
      @(posedge clock) disable iff (srst)
      timer1IrqTaken_ff |-> ($past(globalIrqEnable) && $past(timer1_irq_allow_ff)
                             && (timer1_irq_pending_ff == $past(t1Match)));
   endproperty
   a_irq_take: assert property (p_irq_take) else $error("bad interrupt acceptance");

   property p_reset_modes;
      @(posedge clock) disable iff (srst)
      $past(srst) |-> (timer0Sel_ff == 2'h0 && timer1Sel_ff == 2'h0 && timer1_run_ff
                       && !timer0_run_ff);
   endproperty
   a_reset_modes: assert property (p_reset_modes) else $error("bad mode after reset");

   property p_clear_reads_zero;
      @(posedge clock) disable iff (srst)
      (rfAddr == RF_T0_MODE || rfAddr == RF_T1_MODE) |=> !rfRdata_ff[BIT_CLEAR];
   endproperty
   a_clear_reads_zero: assert property (p_clear_reads_zero) else $error("clear bit read 1");

   property p_start_wait;
      @(posedge clock) disable iff (srst)
      (stab_ff == ST_WAIT && !t1Match) |=> ##1 !programStart_ff;
   endproperty
   a_start_wait: assert property (p_start_wait) else $error("start before wait end");

   property p_toggle;
      @(posedge clock) disable iff (srst)
      (t0Match && !timer0_count_clear_ff) |=> timer0ToggleOutput_ff != $past(timer0ToggleOutput_ff);
   endproperty
   a_toggle: assert property (p_toggle) else $error("toggle missed a match");

   property p_stopped;
      @(posedge clock) disable iff (srst)
      (!timer0_run_ff && !periphRead && !timer0_count_clear_ff) [*2] |=> t0Count == $past(t0Count);
   endproperty
   a_stopped: assert property (p_stopped) else $error("stopped timer counted");

   property p_joint_read;
      @(posedge clock) disable iff (srst)
      (periphRead && periphAddr == ADDR_JOINT_CNT) |=> periphRdata_ff == {t1Count, t0Count};
   endproperty
   a_joint_read: assert property (p_joint_read) else $error("joint count wrong");

endmodule // dual_eight_bit_timer_counter

// file: verification/core_model.sv
// Processor core model: peripheral transfers and register file accesses
`timescale 1ns/1ps
module core_model (
   input  wire logic        clock,
   output logic      [6:0]  periphAddr,
   output logic             periphWrite,
   output logic             periphRead,
   output logic      [15:0] transferBuffer,
   input  wire logic [15:0] periphRdata_ff,
   output logic      [6:0]  rfAddr,
   output logic             rfWrite,
   output logic      [3:0]  rfWdata,
   input  wire logic [3:0]  rfRdata_ff,
   output logic             globalIrqEnable
);
   initial begin
      periphAddr      = 7'h00;
      periphWrite     = 1'b0;
      periphRead      = 1'b0;
      transferBuffer  = 16'h0000;
      rfAddr          = 7'h00;
      rfWrite         = 1'b0;
      rfWdata         = 4'h0;
      globalIrqEnable = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Limits passed here stay within 01h to FFh, zero matches on every pulse
   task automatic pwrite(input logic [6:0] a, input logic [15:0] d);
      @(posedge clock);
      periphAddr     <= a;
      transferBuffer <= d;
      periphWrite    <= 1'b1;
      @(posedge clock);
      periphWrite    <= 1'b0;
      transferBuffer <= ~d;
   endtask
   task automatic pread(input logic [6:0] a, output logic [15:0] d);
      @(posedge clock);
      periphAddr <= a;
      periphRead <= 1'b1;
      @(posedge clock);
      periphRead <= 1'b0;
      #1 d = periphRdata_ff;
   endtask
   task automatic rwrite(input logic [6:0] a, input logic [3:0] d);
      @(posedge clock);
      rfAddr  <= a;
      rfWdata <= d;
      rfWrite <= 1'b1;
      @(posedge clock);
      rfWrite <= 1'b0;
      rfWdata <= ~d;
   endtask
   // Interrupt enable of the core, changed only through this task
   task automatic set_irq_enable(input logic v);
      globalIrqEnable <= v;
   endtask
   task automatic rread(input logic [6:0] a, output logic [3:0] d);
      @(posedge clock);
      rfAddr <= a;
      @(posedge clock);
      #1 d = rfRdata_ff;
   endtask
endmodule // core_model

// file: verification/test_dual_eight_bit_timer_counter.sv
// Self-checking bench for the dual 8-bit timer/counter
`timescale 1ns/1ps
module test_dual_eight_bit_timer_counter;
   import dual_timer_pkg::*;
   logic        clock = 1'b0, srst = 1'b1, extPulsePin = 1'b0;
   logic [6:0]  periphAddr, rfAddr;
   logic        periphWrite, periphRead, rfWrite, globalIrqEnable;
   logic [15:0] transferBuffer, periphRdata_ff, rd, rd2;
   logic [3:0]  rfWdata, rfRdata_ff, rn;
   logic        taken0, taken1, progStart, toggle, pinOut, pinOe, tg;
   int          failures = 0, n_checks = 0, t0, t1;
   always #4 clock = ~clock;
   dual_eight_bit_timer_counter #(.T1_LIMIT_INIT(8'h01)) uut (
      .clock(clock), .srst(srst), .periphAddr(periphAddr), .periphWrite(periphWrite),
      .periphRead(periphRead), .transferBuffer(transferBuffer),
      .periphRdata_ff(periphRdata_ff), .rfAddr(rfAddr), .rfWrite(rfWrite),
      .rfWdata(rfWdata), .rfRdata_ff(rfRdata_ff), .extPulsePin(extPulsePin),
      .globalIrqEnable(globalIrqEnable), .timer0IrqTaken_ff(taken0),
      .timer1IrqTaken_ff(taken1), .programStart_ff(progStart),
      .timer0ToggleOutput_ff(toggle), .timer0PinOut_ff(pinOut), .timer0PinOe_ff(pinOe));
   core_model core (
      .clock(clock), .periphAddr(periphAddr), .periphWrite(periphWrite),
      .periphRead(periphRead), .transferBuffer(transferBuffer),
      .periphRdata_ff(periphRdata_ff), .rfAddr(rfAddr), .rfWrite(rfWrite),
      .rfWdata(rfWdata), .rfRdata_ff(rfRdata_ff), .globalIrqEnable(globalIrqEnable));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      if (failures == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Bounded wait: timer 0 taken (sel 0), program start (sel 1), timer 1 taken (sel 2)
   task automatic wait_for(input int sel, input int lim, output int cyc);
      cyc = 0;
      do begin
         @(posedge clock);
         #1 cyc++;
         if (cyc > lim) begin
            chk(16'hDEAD, 16'h0000);
            tally_and_finish();
         end
      end while (!((sel == 0) ? taken0 === 1'b1 :
                   (sel == 1) ? progStart === 1'b1 : taken1 === 1'b1));
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge clock);
      srst <= 1'b0;
      core.rread(RF_T1_MODE, rn); chk(rn, 16'h8);
      core.rread(RF_T0_MODE, rn); chk(rn, 16'h0);
      core.pread(ADDR_JOINT_CNT, rd); chk(rd, 16'h0000);
      chk(progStart, 16'h0);
      wait_for(1, 3000, t0); chk(progStart, 16'h1);
      chk(t0 >= 1018 && t0 <= 1022, 16'h1);
      // Timer 0 limit 3 at clock/16, high buffer bits must be ignored
      core.pwrite(ADDR_T0_LIMIT, 16'hA503);
      core.pwrite(7'h04, 16'h0001);
      core.rwrite(RF_IRQ_ALLOW, 4'h1);
      core.rwrite(RF_PIN_SEL, 4'h8);
      core.set_irq_enable(1'b1);
      core.rwrite(RF_T0_MODE, 4'hE);
      core.rread(RF_T0_MODE, rn); chk(rn, 16'hA);
      wait_for(0, 300, t0);
      tg = toggle;
      wait_for(0, 300, t0); chk(t0, 64);
      chk(toggle, !tg);
      chk({pinOut, pinOe}, {1'b0, !toggle});
      core.pwrite(ADDR_T0_LIMIT, 16'h0003);
      wait_for(0, 300, t0);
      wait_for(0, 300, t0); chk(t0, 64);
      // Requests stay pending while globally masked
      @(posedge clock);
      core.set_irq_enable(1'b0);
      repeat (80) @(posedge clock);
      core.rread(RF_IRQ_PEND, rn); chk(rn & 4'h1, 16'h1);
      chk(taken0, 16'h0);
      core.set_irq_enable(1'b1);
      wait_for(0, 10, t1);
      // Cascade: timer 1 counts timer 0 matches, limit 1 gives 2 x 64 cycles
      core.pwrite(ADDR_T1_LIMIT, 16'h0001);
      core.rwrite(RF_T1_MODE, 4'hF);
      core.rwrite(RF_IRQ_ALLOW, 4'h3);
      wait_for(2, 4, t1);
      wait_for(2, 300, t1);
      wait_for(2, 300, t1); chk(t1, 128);
      // Three waits: the first may be a request left from the previous source
      core.rwrite(RF_T1_MODE, 4'hE);
      wait_for(2, 1200, t1);
      wait_for(2, 600, t1);
      wait_for(2, 600, t1); chk(t1, 512);
      core.rwrite(RF_T1_MODE, 4'hD);
      wait_for(2, 4200, t1);
      wait_for(2, 2100, t1);
      wait_for(2, 2100, t1); chk(t1, 2048);
      // Stopping freezes the count
      core.rwrite(RF_T0_MODE, 4'h2);
      core.rread(RF_T0_MODE, rn); chk(rn, 16'h2);
      core.pread(ADDR_JOINT_CNT, rd);
      repeat (100) @(posedge clock);
      core.pread(ADDR_JOINT_CNT, rd2); chk(rd2[7:0], rd[7:0]);
      chk(rd[7:0] <= 8'h03, 16'h1);
      // External pin; each of the three loop pulses lands during a read and is applied after it
      core.rwrite(RF_T0_MODE, 4'hF);
      core.pread(ADDR_JOINT_CNT, rd); chk(rd[7:0], 8'h00);
      for (int i = 0; i < 3; i++) begin
         @(posedge clock);
         extPulsePin <= 1'b1;
         repeat (2) @(posedge clock);
         core.pread(ADDR_JOINT_CNT, rd); chk(rd[7:0], i[7:0]);
         @(posedge clock);
         extPulsePin <= 1'b0;
         repeat (4) @(posedge clock);
      end
      core.pread(ADDR_JOINT_CNT, rd); chk(rd[7:0], 8'h03);
      @(posedge clock);
      extPulsePin <= 1'b1;
      wait_for(0, 20, t0);
      core.pread(7'h10, rd); chk(rd, 16'h0000);
      core.pread(ADDR_T0_LIMIT, rd); chk(rd, 16'h0000);
      tally_and_finish();
   end
endmodule // test_dual_eight_bit_timer_counter
